// ==== core_reader_pkg.sv ====
// constants and carrier types for the indirect core register reader
package core_reader_pkg;

  // ---------------------------------------------------------------
  // register map, byte offsets inside the block
  // ---------------------------------------------------------------
  localparam int          LOCAL_AW       = 12;
  localparam logic [11:0] OFS_DMA_VALUE  = 12'h000;
  localparam logic [11:0] OFS_CORE_REQ   = 12'h004;
  localparam logic [11:0] OFS_CORE_VALUE = 12'h008;
  localparam logic [11:0] OFS_WIN_LO     = 12'h200;
  localparam logic [11:0] OFS_WIN_HI     = 12'h334;

  // ---------------------------------------------------------------
  // field layout of core_read_request
  // ---------------------------------------------------------------
  localparam int REQ_BIT   = 31;
  localparam int CLR_BIT   = 30;
  localparam int ADDR_MSB  = 9;
  localparam int ADDR_LSB  = 2;
  localparam int CORE_AW   = ADDR_MSB - ADDR_LSB + 1;
  localparam int CORE_DW   = 16;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NSEQ_BIT_SEL = 2'h2;

  // ---------------------------------------------------------------
  // carrier towards the usb_device_core register port
  // ---------------------------------------------------------------
  typedef struct packed {
    logic               req;
    logic               we;
    logic [CORE_AW-1:0] addr;
    logic [31:0]        wdata;
  } core_req_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_READ  = 4'h2,
    ST_WRITE = 4'h4,
    ST_ABORT = 4'h8
  } reader_state_t;

endpackage

// ==== indirect_core_register_reader.sv ====
// ahb-lite slave bridging indirect reads and guarded writes to the usb device core
`timescale 1ns/10ps
`default_nettype none
module indirect_core_register_reader
  import core_reader_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_resetn,
  input  wire logic                i_hsel,
  input  wire logic [LOCAL_AW-1:0] i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic [31:0]         i_hwdata,
  input  wire logic                i_hready,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  output logic [31:0]              o_hrdata,
  output core_req_t                o_core,
  input  wire logic                i_core_ack,
  input  wire logic [CORE_DW-1:0]  i_core_rdata,
  input  wire logic                i_dma_done,
  input  wire logic [31:0]         i_dma_rdata,
  output logic                     o_core_read_done
);

  // ---------------------------------------------------------------
  // ahb address and data phase
  // ---------------------------------------------------------------
  logic                dp_valid_q;
  logic                dp_write_q;
  logic [LOCAL_AW-1:0] dp_addr_q;
  logic                err_second_q;
  logic [31:0]         rdata_q;
  logic [31:0]         dma_val_q;
  logic [CORE_DW-1:0]  core_val_q;
  logic [CORE_AW-1:0]  addr_q;
  logic [31:0]         wdata_q;
  logic                done_q;
  reader_state_t       state_q;
  reader_state_t       state_d;

  wire ap_take  = i_hsel & ((i_htrans & HTRANS_NSEQ_BIT_SEL) != 2'h0) & i_hready;
  wire hit_dma  = dp_addr_q == OFS_DMA_VALUE;
  wire hit_req  = dp_addr_q == OFS_CORE_REQ;
  wire hit_val  = dp_addr_q == OFS_CORE_VALUE;
  wire hit_win  = (dp_addr_q >= OFS_WIN_LO) && (dp_addr_q <= OFS_WIN_HI) &&
                  (dp_addr_q[1:0] == 2'h0);
  wire req_bit  = (state_q == ST_READ) || (state_q == ST_WRITE);
  wire clr_bit  = state_q == ST_ABORT;
  wire busy     = req_bit | clr_bit;
  wire unmapped = ~(hit_dma | hit_req | hit_val | hit_win);
  // the stalled transfer stays in the data phase registers during the second error
  // cycle; it is masked there so that a refused write never runs once the port frees
  wire dp_live  = dp_valid_q & ~err_second_q;
  // a busy core port refuses window writes; the bridge never queues them
  wire err_now  = dp_live & (unmapped | (hit_win & dp_write_q & busy));
  wire wr_req   = dp_live & dp_write_q & hit_req;
  wire clr_go   = wr_req & i_hwdata[CLR_BIT];
  wire rd_go    = wr_req & i_hwdata[REQ_BIT] & ~i_hwdata[CLR_BIT] & ~busy;
  wire wr_go    = dp_live & dp_write_q & hit_win & ~busy;
  wire [CORE_AW-1:0] req_addr = i_hwdata[ADDR_MSB:ADDR_LSB];
  wire [CORE_AW-1:0] win_addr = dp_addr_q[ADDR_MSB:ADDR_LSB];
  wire rd_end   = (state_q == ST_READ) & i_core_ack & ~clr_go;

  assign o_hreadyout = ~err_now;
  assign o_hresp     = err_now | err_second_q;
  assign o_hrdata    = rdata_q;

  wire l_ap_dma = i_haddr == OFS_DMA_VALUE;
  wire l_ap_req = i_haddr == OFS_CORE_REQ;
  wire l_ap_val = i_haddr == OFS_CORE_VALUE;
  wire [31:0] req_word = {req_bit, clr_bit, 20'h00000, addr_q, 2'h0};
  wire [31:0] rdata_d  = l_ap_dma ? dma_val_q :
                         l_ap_req ? req_word :
                         l_ap_val ? {16'h0000, core_val_q} :
                         RESET_WORD;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dp_valid_q   <= 1'b0;
      dp_write_q   <= 1'b0;
      dp_addr_q    <= '0;
      err_second_q <= 1'b0;
      rdata_q      <= RESET_WORD;
    end else begin
      err_second_q <= err_now;
      if (i_hready) begin
        dp_valid_q <= ap_take;
        dp_write_q <= i_hwrite;
        dp_addr_q  <= i_haddr;
      end
      if (ap_take && !i_hwrite) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // core access sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (clr_go) begin
          state_d = ST_ABORT;
        end else if (rd_go) begin
          state_d = ST_READ;
        end else if (wr_go) begin
          state_d = ST_WRITE;
        end
      end
      ST_READ, ST_WRITE: begin
        if (clr_go) begin
          state_d = ST_ABORT;
        end else if (i_core_ack) begin
          state_d = ST_IDLE;
        end
      end
      ST_ABORT: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // an aborted strobe is dropped mid-flight, so the core may see a torn access
  wire core_we = state_q == ST_WRITE;
  assign o_core = {req_bit, core_we, addr_q, wdata_q};
  assign o_core_read_done = done_q;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q    <= ST_IDLE;
      addr_q     <= '0;
      wdata_q    <= RESET_WORD;
      core_val_q <= '0;
      dma_val_q  <= RESET_WORD;
      done_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= rd_end;
      if (rd_go) begin
        addr_q <= req_addr;
      end else if (wr_go) begin
        addr_q <= win_addr;
      end
      if (wr_go) begin
        wdata_q <= i_hwdata;
      end
      if (rd_end) begin
        core_val_q <= i_core_rdata;
      end
      if (i_dma_done) begin
        dma_val_q <= i_dma_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  AST_DMA_HOLD: assert property (
    i_dma_done |=> (dma_val_q == $past(i_dma_rdata)))
    else $error("dma value not captured");
  AST_READ_START: assert property (
    rd_go |=> (o_core.req && !o_core.we && o_core.addr == $past(req_addr)))
    else $error("core read did not start at requested address");
  AST_READ_STORE: assert property (
    rd_end |=> (core_val_q == $past(i_core_rdata)) && !req_bit && o_core_read_done)
    else $error("read completion not stored or flagged");
  AST_DONE_CAUSE: assert property (
    o_core_read_done |-> $past(state_q == ST_READ) && !o_core.req)
    else $error("done flag without a finished read");
  AST_BUSY_WRITE: assert property (
    wr_go |=> (req_word[REQ_BIT] && o_core.we) [*1] ##0 (rdata_d[REQ_BIT] || !l_ap_req))
    else $error("write in flight not shown as busy");
  AST_ABORT: assert property (
    (clr_go && busy && !clr_bit) |=> (!o_core.req && clr_bit) ##1 !clr_bit)
    else $error("forced clear did not abort");
  AST_CLR_SELF: assert property (
    clr_bit |=> !clr_bit && !req_bit)
    else $error("forced clear bit stuck");
  AST_WR_BLOCK: assert property (
    (dp_live && dp_write_q && hit_win && busy) |-> (o_hresp && !o_hreadyout)
      ##1 (o_hresp && o_hreadyout && !wr_go))
    else $error("blocked core write not answered with error");
  AST_UPPER_ZERO: assert property (
    (ap_take && !i_hwrite && l_ap_val) |=> (o_hrdata[31:16] == 16'h0000))
    else $error("core value upper half not zero");
  // a refused transfer is let go in the second error cycle and must not act
  AST_ERR_RELEASE: assert property (
    err_now |=> (o_hresp && o_hreadyout && !wr_req && !wr_go))
    else $error("error response not two cycles or refused transfer acted on");
  AST_CLR_WINS: assert property (
    (clr_go && (state_q == ST_READ)) |=> (!o_core_read_done && !o_core.req))
    else $error("aborted read still flagged as done");
  AST_WRITE_START: assert property (
    wr_go |=> (o_core.req && o_core.we && o_core.addr == $past(win_addr)))
    else $error("core write did not start at window address");

  COV_READ: cover property (rd_go ##[1:20] o_core_read_done);
  COV_WRITE: cover property (wr_go ##[1:20] (state_q == ST_IDLE));
  COV_ABORT: cover property ((state_q == ST_READ) ##1 clr_go);
  COV_ERR: cover property (err_now && hit_win);
  COV_BUSY_POLL: cover property ((state_q == ST_WRITE) && ap_take && l_ap_req && !i_hwrite);

endmodule
`default_nettype wire

// ==== core_model.sv ====
// behavioural usb_device_core register port that answers after a set delay
`timescale 1ns/10ps
`default_nettype none
module core_model
  import core_reader_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire core_req_t          i_core,
  input  wire logic [7:0]         i_delay,
  output logic                    o_ack,
  output logic [CORE_DW-1:0]      o_rdata
);
  logic [7:0] cnt_q;
  wire        fire = i_core.req && !o_ack && (cnt_q == i_delay);
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q   <= 8'h00;
      o_ack   <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_ack   <= fire;
      // a dropped request restarts the wait, as after an abort
      cnt_q   <= (i_core.req && !o_ack) ? cnt_q + 8'h01 : 8'h00;
      // data only means something with the ack; otherwise it keeps toggling
      o_rdata <= fire ? {i_core.addr, ~i_core.addr} : ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== indirect_core_register_reader_tb_top.sv ====
// self-checking bench for the indirect core register reader
`timescale 1ns/10ps
`default_nettype none
module indirect_core_register_reader_tb_top;
  import core_reader_pkg::*;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic rs;} row_t;
  logic i_mclk, i_resetn, i_hsel, i_hwrite, o_hreadyout, o_hresp, ack, o_core_read_done;
  logic i_dma_done;
  logic [11:0] i_haddr;
  logic [1:0] i_htrans;
  logic [31:0] i_hwdata, o_hrdata, i_dma_rdata, rd;
  logic [15:0] cdata;
  logic [7:0] dly;
  logic rs;
  core_req_t core;
  int num_errors, samples_checked, dones;
  row_t rows[11] = '{
    '{0, 12'h000, 0, 0, 0}, '{0, 12'h004, 0, 0, 0}, '{0, 12'h008, 0, 0, 0},
    '{0, 12'h200, 0, 0, 0}, '{0, 12'h334, 0, 0, 0}, '{0, 12'h00c, 0, 0, 1},
    '{1, 12'h100, 0, 0, 1}, '{0, 12'h202, 0, 0, 1}, '{0, 12'h338, 0, 0, 1},
    '{1, 12'h000, 32'hffff_ffff, 0, 0}, '{0, 12'h000, 0, 0, 0}};
  indirect_core_register_reader DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .o_core(core), .i_core_ack(ack), .i_core_rdata(cdata),
    .i_dma_done(i_dma_done), .i_dma_rdata(i_dma_rdata), .o_core_read_done(o_core_read_done));
  core_model PEER (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_core(core), .i_delay(dly),
    .o_ack(ack), .o_rdata(cdata));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) if (o_core_read_done === 1'b1) dones++;
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask
  // one ahb transfer; the answer is sampled half a cycle before the edge that takes it
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    i_hsel = 1'b1;
    i_htrans = 2'h2;
    i_haddr = a;
    i_hwrite = w;
    @(posedge i_mclk) #1;
    i_hsel = 1'b0;
    i_htrans = 2'h0;
    i_hwdata = d;
    n = 0;
    do @(negedge i_mclk); while (o_hreadyout !== 1'b1 && ++n < 8);
    chk_bit("hreadyout", 1'b1, o_hreadyout);
    rd = o_hrdata;
    rs = o_hresp;
    @(posedge i_mclk) #1;
  endtask
  task automatic poll_idle;
    int n;
    n = 0;
    do bus(0, OFS_CORE_REQ, 0); while (rd[31:30] !== 2'h0 && ++n < 100);
    chk_word("idle poll", 32'h0, {rd[31:30], 30'h0});
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial begin
    {i_resetn, i_hsel, i_hwrite, i_dma_done, i_haddr, i_htrans, i_hwdata, i_dma_rdata} = '0;
    dly = 8'h03;
    repeat (8) @(posedge i_mclk);
    #1 i_resetn = 1'b1;
    foreach (rows[k]) begin
      bus(rows[k].wr, rows[k].a, rows[k].wd);
      chk_word("row rdata", rows[k].rd, rd);
      chk_bit("row resp", rows[k].rs, rs);
    end
    bus(1, OFS_CORE_REQ, 32'h8000_0000 | (32'h0cd << 2));
    chk_bit("req resp", 1'b0, rs);
    poll_idle();
    chk_word("done pulses", 1, dones);
    bus(0, OFS_CORE_VALUE, 0);
    chk_word("core value", {16'h0, 8'hcd, 8'h32}, rd);
    dly = 8'h28;
    bus(1, OFS_WIN_HI, 32'h1234_5678);
    bus(0, OFS_CORE_REQ, 0);
    bus(0, OFS_CORE_REQ, 0);
    chk_bit("busy bit", 1'b1, rd[31]);
    chk_bit("core we", 1'b1, core.we);
    chk_word("core wdata", 32'h1234_5678, core.wdata);
    chk_word("core addr", 32'h0000_00cd, {24'h0, core.addr});
    bus(1, 12'h210, 32'h0);
    chk_bit("write while busy", 1'b1, rs);
    poll_idle();
    bus(1, OFS_CORE_REQ, 32'h8000_0000 | (32'h080 << 2));
    bus(1, OFS_CORE_REQ, 32'h4000_0000);
    bus(0, OFS_CORE_REQ, 0);
    chk_word("abort clear bit", 32'h4000_0000, {rd[31:30], 30'h0});
    bus(0, OFS_CORE_REQ, 0);
    chk_word("after abort", 32'h0, {rd[31:30], 30'h0});
    repeat (60) @(posedge i_mclk);
    chk_word("no done on abort", 1, dones);
    i_dma_done = 1'b1;
    i_dma_rdata = 32'hcafe_1234;
    @(posedge i_mclk) #1;
    i_dma_done = 1'b0;
    @(posedge i_mclk) #1;
    bus(0, OFS_DMA_VALUE, 0);
    chk_word("dma value", 32'hcafe_1234, rd);
    // reset in the middle of a core read
    bus(1, OFS_CORE_REQ, 32'h8000_0000 | (32'h090 << 2));
    i_resetn = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 i_resetn = 1'b1;
    chk_bit("req after reset", 1'b0, core.req);
    bus(0, OFS_CORE_REQ, 0);
    chk_word("req reg after reset", 32'h0, rd);
    bus(0, OFS_CORE_VALUE, 0);
    chk_word("value after reset", 32'h0, rd);
    bus(0, OFS_DMA_VALUE, 0);
    chk_word("dma after reset", 32'h0, rd);
    chk_word("done after reset", 1, dones);
    end_sim();
  end
endmodule
`default_nettype wire
